// File: intc_cfg.svh
// register offsets, field positions and reset values of the interrupt controller
`ifndef INTC_CFG_SVH
`define INTC_CFG_SVH
`define NUM_SOURCES 40
`define NUM_LEVELS 32
`define LEVEL_W 5
`define ADDR_W 8
// word offsets (byte addresses)
`define OFF_FORCE_HIGH 8'h00
`define OFF_FORCE_LOW 8'h04
`define OFF_LEVEL_PEND 8'h08
`define OFF_FAST_EN 8'h0c
`define OFF_FAST_PEND 8'h10
`define OFF_NORM_EN 8'h14
`define OFF_NORM_PEND 8'h18
`define OFF_CONTROL 8'h1c
`define OFF_STATUS 8'h20
`define OFF_LEVEL_SEL_BASE 8'h40
`define OFF_LEVEL_SEL_LAST 8'hdc
// control register fields
`define CTL_MASK_LSB 0
`define CTL_MASK_MSB 4
`define CTL_ME_BIT 5
`define CTL_MFI_BIT 6
`define CTL_FVE_BIT 7
`define CTL_AE_BIT 8
`define CTL_RESET 9'h100
// status register fields
`define ST_VEC_LSB 0
`define ST_VEC_MSB 6
`define ST_FAST_BIT 8
`define ST_NORM_BIT 9
// vector bits 6:5
`define VEC_HI_NORMAL 2'h1
`define VEC_HI_FAST 2'h2
`define FORCE_HIGH_W 8
// reset values
`define FORCE_HIGH_RESET 8'h00
`define FORCE_LOW_RESET 32'h0000_0000
`define FAST_EN_RESET 32'h0000_0000
`define NORM_EN_RESET 32'h0000_0000
`define LEVEL_SEL_RESET 5'h00
// level select word field
`define LEVEL_CODE_LSB 0
`define LEVEL_CODE_MSB 4
`endif

// File: intc_pkg.sv
// types shared by the interrupt controller
package intc_pkg;
  typedef struct packed {
    logic autovector_enable;
    logic fast_vector_separation;
    logic mask_scope_select;
    logic mask_enable;
    logic [4:0] mask_level;
  } control_type;
  typedef struct packed {
    logic fast_req_n;
    logic normal_req_n;
    logic [6:0] vector;
  } core_req_type;
endpackage

// File: intc.sv
// prioritized interrupt controller with register port
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "intc_cfg.svh"

module intc
  import intc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // interrupt sources, held levels from same-clock modules
  input wire logic [`NUM_SOURCES-1:0] source_req,
  // register port
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // to processor core
  output core_req_type core_req,
  output logic vector_valid,
  output logic raw_fast_req_n,
  output logic raw_normal_req_n
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] prio_enc(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // mask of levels at and below a given level
  function automatic logic [31:0] low_mask(input logic [4:0] lvl);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (5'(i) <= lvl) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // one-hot code of a level
  function automatic logic [31:0] lvl_onehot(input logic [4:0] lvl);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[lvl] = 1'b1;
    return m;
  endfunction

  // write strobe aimed at one word offset; writes elsewhere, including the
  // read-only pending and status words, change nothing
  function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] off);
    return w && (a == off);
  endfunction

  // address falls on one of the level select words
  function automatic logic sel_hit(input logic [7:0] a);
    return (a >= `OFF_LEVEL_SEL_BASE) && (a <= `OFF_LEVEL_SEL_LAST) && (a[1:0] == 2'h0);
  endfunction

  // source number of a level select word, meaningful only where sel_hit holds
  function automatic logic [5:0] sel_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `OFF_LEVEL_SEL_BASE;
    return d[7:2];
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [`FORCE_HIGH_W-1:0] force_request_high;
  logic [31:0] force_request_low;
  logic [31:0] fast_enable_vector;
  logic [31:0] normal_enable_vector;
  logic [4:0] level_select_regs [`NUM_SOURCES];
  control_type controller_control_reg;

  // software force bits for sources 39..32
  always_ff @(posedge clk) begin
    if (rst) begin
      force_request_high <= `FORCE_HIGH_RESET;
    end else if (wr_hit(wr, addr, `OFF_FORCE_HIGH)) begin
      force_request_high <= wdata[`FORCE_HIGH_W-1:0];
    end
  end

  // software force bits for sources 31..0
  always_ff @(posedge clk) begin
    if (rst) begin
      force_request_low <= `FORCE_LOW_RESET;
    end else if (wr_hit(wr, addr, `OFF_FORCE_LOW)) begin
      force_request_low <= wdata;
    end
  end

  // levels allowed to raise the fast line
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_enable_vector <= `FAST_EN_RESET;
    end else if (wr_hit(wr, addr, `OFF_FAST_EN)) begin
      fast_enable_vector <= wdata;
    end
  end

  // levels allowed to raise the normal line
  always_ff @(posedge clk) begin
    if (rst) begin
      normal_enable_vector <= `NORM_EN_RESET;
    end else if (wr_hit(wr, addr, `OFF_NORM_EN)) begin
      normal_enable_vector <= wdata;
    end
  end

  // mode and mask controls; autovectoring is on out of reset
  always_ff @(posedge clk) begin
    if (rst) begin
      controller_control_reg <= control_type'(`CTL_RESET);
    end else if (wr_hit(wr, addr, `OFF_CONTROL)) begin
      controller_control_reg.autovector_enable <= wdata[`CTL_AE_BIT];
      controller_control_reg.fast_vector_separation <= wdata[`CTL_FVE_BIT];
      controller_control_reg.mask_scope_select <= wdata[`CTL_MFI_BIT];
      controller_control_reg.mask_enable <= wdata[`CTL_ME_BIT];
      controller_control_reg.mask_level <= wdata[`CTL_MASK_MSB:`CTL_MASK_LSB];
    end
  end

  // one level select word per source; only the low five bits are kept,
  // the rest of the word reads back as zero
  genvar gs;
  generate
    for (gs = 0; gs < `NUM_SOURCES; gs++) begin : g_sel
      always_ff @(posedge clk) begin
        if (rst) begin
          level_select_regs[gs] <= `LEVEL_SEL_RESET;
        end else if (wr && sel_hit(addr) && (sel_index(addr) == 6'(gs))) begin
          level_select_regs[gs] <= wdata[`LEVEL_CODE_MSB:`LEVEL_CODE_LSB];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // level pending and fast/normal split
  // ---------------------------------------------------------------
  logic [`NUM_SOURCES-1:0] combined_req;
  logic [31:0] level_pending_vector;
  logic [31:0] fast_pending_vector;
  logic [31:0] normal_pending_vector;
  logic [31:0] fast_mask;
  logic [31:0] normal_mask;

  // purely level based, no edge detection: a source holds its line for as
  // long as it drives source_req, and a forced bit stays until it is written back
  assign combined_req = source_req | {force_request_high, force_request_low};

  // one-hot level of each source, empty while the source is quiet
  logic [31:0] source_hit [`NUM_SOURCES];
  genvar gh;
  generate
    for (gh = 0; gh < `NUM_SOURCES; gh++) begin : g_hit
      assign source_hit[gh] = combined_req[gh] ? lvl_onehot(level_select_regs[gh]) :
                              32'h0000_0000;
    end
  endgenerate

  // a level is pending while any source placed on it requests; this
  // word is never masked
  always_comb begin
    level_pending_vector = 32'h0000_0000;
    for (int s = 0; s < `NUM_SOURCES; s++) begin
      level_pending_vector = level_pending_vector | source_hit[s];
    end
  end

  // levels at and below the programmed floor, shared by both masks
  logic [31:0] mask_floor;
  assign mask_floor = low_mask(controller_control_reg.mask_level);

  // fast requests are masked only when the scope bit reaches them
  always_comb begin
    fast_mask = 32'hffff_ffff;
    if (controller_control_reg.mask_enable && controller_control_reg.mask_scope_select) begin
      fast_mask = ~mask_floor;
    end
  end

  // normal requests lose the floor, or everything when the scope bit is set
  always_comb begin
    normal_mask = 32'hffff_ffff;
    if (controller_control_reg.mask_enable) begin
      if (controller_control_reg.mask_scope_select) begin
        normal_mask = 32'h0000_0000;
      end else begin
        normal_mask = ~mask_floor;
      end
    end
  end

  // per-level split into the two request classes; masking is folded in,
  // so software reads the masked view of both pending words
  genvar gl;
  generate
    for (gl = 0; gl < `NUM_LEVELS; gl++) begin : g_split
      // a level enabled in both classes shows in both pending words
      assign fast_pending_vector[gl] = fast_enable_vector[gl] & level_pending_vector[gl] &
                                       fast_mask[gl];
      assign normal_pending_vector[gl] = normal_enable_vector[gl] & level_pending_vector[gl] &
                                         normal_mask[gl];
    end
  endgenerate

  // ---------------------------------------------------------------
  // raw request lines and vector
  // ---------------------------------------------------------------
  logic fast_any;
  logic normal_any;
  logic [4:0] fast_level;
  logic [4:0] normal_level;
  logic [6:0] vector_next;
  logic [1:0] fast_hi_bits;

  assign fast_any = |fast_pending_vector;
  assign normal_any = |normal_pending_vector;
  // the raw lines skip the output stage so a request can wake a core whose
  // clocks are stopped; they may glitch while a register write settles
  assign raw_fast_req_n = ~fast_any;
  assign raw_normal_req_n = ~(normal_any & ~fast_any);
  assign fast_level = prio_enc(fast_pending_vector);
  assign normal_level = prio_enc(normal_pending_vector);

  // ---------------------------------------------------------------
  // vector number
  // ---------------------------------------------------------------
  // separated fast requests use the upper half of the vector table
  assign fast_hi_bits = controller_control_reg.fast_vector_separation ? `VEC_HI_FAST :
                        `VEC_HI_NORMAL;

  // fast wins even over a higher normal level; an idle core sees vector zero
  always_comb begin
    vector_next = 7'h00;
    if (fast_any) begin
      vector_next[4:0] = fast_level;
      vector_next[6:5] = fast_hi_bits;
    end else if (normal_any) begin
      vector_next[4:0] = normal_level;
      vector_next[6:5] = `VEC_HI_NORMAL;
    end
  end

  // ---------------------------------------------------------------
  // output register stage
  // ---------------------------------------------------------------
  // one register stage toward the core, adding a clock of latency; the
  // raw lines skip it
  always_ff @(posedge clk) begin
    if (rst) begin
      core_req <= '{fast_req_n: 1'b1, normal_req_n: 1'b1, vector: 7'h00};
    end else begin
      core_req.fast_req_n <= raw_fast_req_n;
      core_req.normal_req_n <= raw_normal_req_n;
      core_req.vector <= vector_next;
    end
  end

  // marks vectored presentation, aligned with the staged request lines;
  // it stays low while autovectoring is on
  always_ff @(posedge clk) begin
    if (rst) begin
      vector_valid <= 1'b0;
    end else begin
      vector_valid <= ~controller_control_reg.autovector_enable &
                      (fast_any | normal_any);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [31:0] rdata_next;
  logic [31:0] status_word;
  logic [31:0] control_word;

  // status shows the staged lines and vector, exactly as the core sees
  // them, one clock behind the raw lines
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_VEC_MSB:`ST_VEC_LSB] = core_req.vector;
    status_word[`ST_FAST_BIT] = core_req.fast_req_n;
    status_word[`ST_NORM_BIT] = core_req.normal_req_n;
  end

  // control reads back in its own bit layout
  assign control_word = {23'h00_0000, controller_control_reg};

  // unmapped words read as zero; the pending words are views with no
  // storage of their own, so writes to them cannot land
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (addr)
      `OFF_FORCE_HIGH: rdata_next = {24'h00_0000, force_request_high};
      `OFF_FORCE_LOW: rdata_next = force_request_low;
      `OFF_LEVEL_PEND: rdata_next = level_pending_vector;
      `OFF_FAST_EN: rdata_next = fast_enable_vector;
      `OFF_FAST_PEND: rdata_next = fast_pending_vector;
      `OFF_NORM_EN: rdata_next = normal_enable_vector;
      `OFF_NORM_PEND: rdata_next = normal_pending_vector;
      `OFF_CONTROL: rdata_next = control_word;
      `OFF_STATUS: rdata_next = status_word;
      default: begin
        if (sel_hit(addr)) begin
          rdata_next = {27'h000_0000, level_select_regs[sel_index(addr)]};
        end
      end
    endcase
  end

  // read data stand for one cycle only and are zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule

// File: intc_assertions.sv
// port assertions for the interrupt controller
`timescale 1ns/1ps
module intc_assertions
  import intc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire logic [39:0] source_req,
  input wire logic wr,
  input wire core_req_type core_req,
  input wire logic vector_valid,
  input wire logic raw_fast_req_n,
  input wire logic raw_normal_req_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_raw_normal_yields:
    assert property (!raw_fast_req_n |-> raw_normal_req_n)
      else $error("raw normal line active beside raw fast line");
  a_core_normal_yields:
    assert property (!core_req.fast_req_n |-> core_req.normal_req_n)
      else $error("normal line active beside fast line");
  a_fast_stage:
    assert property (!$past(rst) |-> core_req.fast_req_n == $past(raw_fast_req_n))
      else $error("fast line not one clock behind raw line");
  a_normal_stage:
    assert property (!$past(rst) |-> core_req.normal_req_n == $past(raw_normal_req_n))
      else $error("normal line not one clock behind raw line");
  a_normal_vec_bits:
    assert property (!core_req.normal_req_n |-> core_req.vector[6:5] == 2'h1)
      else $error("normal vector upper bits wrong");
  a_fast_vec_bits:
    assert property (!core_req.fast_req_n |-> core_req.vector[6:5] inside {2'h1, 2'h2})
      else $error("fast vector upper bits wrong");
  a_idle_vector:
    assert property (core_req.fast_req_n && core_req.normal_req_n |-> core_req.vector == 7'h0)
      else $error("vector not zero while idle");
  a_vectored_flag:
    assert property (vector_valid |-> !(core_req.fast_req_n && core_req.normal_req_n))
      else $error("vectored flag without request");
  a_level_inputs:
    assert property (!$past(rst) && !$past(wr) && $stable(source_req)
      |-> $stable(raw_fast_req_n) && $stable(raw_normal_req_n))
      else $error("raw lines moved with steady inputs");
endmodule
bind intc intc_assertions chk (.clk(clk), .rst(rst), .source_req(source_req), .wr(wr),
  .core_req(core_req), .vector_valid(vector_valid), .raw_fast_req_n(raw_fast_req_n),
  .raw_normal_req_n(raw_normal_req_n));

// File: core_model.sv
// processor core side: records the last request it takes
`timescale 1ns/1ps
module core_model
  import intc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests from the controller
  input wire core_req_type core_req,
  // last request taken
  output logic [6:0] taken_vector,
  output logic taken_fast
);
  always_ff @(posedge clk) begin
    if (rst) begin
      taken_vector <= 7'h0;
      taken_fast <= 1'b0;
    end else if (!core_req.fast_req_n || !core_req.normal_req_n) begin
      taken_vector <= core_req.vector;
      taken_fast <= !core_req.fast_req_n;
    end
  end
endmodule

// File: intc_tb.sv
// self-checking testbench for the interrupt controller
`timescale 1ns/1ps
`include "intc_cfg.svh"
module intc_tb
  import intc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [39:0] source_req = 40'h0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  core_req_type core_req;
  logic vector_valid;
  logic raw_fast_req_n;
  logic raw_normal_req_n;
  logic [6:0] taken_vector;
  logic taken_fast;
  int errors = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  intc DUT (.clk(clk), .rst(rst), .source_req(source_req), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .core_req(core_req), .vector_valid(vector_valid),
    .raw_fast_req_n(raw_fast_req_n), .raw_normal_req_n(raw_normal_req_n));
  core_model pm (.clk(clk), .rst(rst), .core_req(core_req), .taken_vector(taken_vector),
    .taken_fast(taken_fast));
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cq(input logic [8:0] e);
    chk("core_req", {23'h0, e}, {23'h0, core_req});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    step(1);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  task automatic src(input logic [39:0] v);
    @(posedge clk);
    source_req <= v;
    #1;
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset;
    rreg(`OFF_CONTROL, 32'h100);
    rreg(8'h4c, 32'h0);
    rreg(8'h3c, 32'h0);
    cq(9'h180);
  endtask
  task automatic t_fast;
    wreg(8'h4c, 32'h7);
    wreg(`OFF_FAST_EN, 32'h80);
    src(40'h8);
    chk("raw_fast", 32'h0, {31'h0, raw_fast_req_n});
    cq(9'h180);
    step(1);
    cq(9'h0a7);
    chk("vector_valid", 32'h0, {31'h0, vector_valid});
    rreg(`OFF_LEVEL_PEND, 32'h80);
    rreg(`OFF_FAST_PEND, 32'h80);
    wreg(`OFF_CONTROL, 32'h0);
    chk("vector_valid", 32'h1, {31'h0, vector_valid});
    cq(9'h0a7);
    wreg(`OFF_CONTROL, 32'h80);
    cq(9'h0c7);
    rreg(`OFF_STATUS, 32'h247);
    wreg(`OFF_FAST_PEND, 32'h0);
    rreg(`OFF_FAST_PEND, 32'h80);
    chk("taken", 32'hc7, {24'h0, taken_fast, taken_vector});
  endtask
  task automatic t_prio;
    wreg(`OFF_CONTROL, 32'h0);
    wreg(8'h68, 32'h1f);
    wreg(`OFF_NORM_EN, 32'h8000_0000);
    wreg(`OFF_FORCE_LOW, 32'h400);
    cq(9'h0a7);
    chk("raw_normal", 32'h1, {31'h0, raw_normal_req_n});
    src(40'h0);
    chk("raw_normal", 32'h0, {31'h0, raw_normal_req_n});
    chk("raw_fast", 32'h1, {31'h0, raw_fast_req_n});
    step(1);
    cq(9'h13f);
    rreg(`OFF_NORM_PEND, 32'h8000_0000);
    wreg(`OFF_FAST_EN, 32'h8000_0000);
    cq(9'h0bf);
    rreg(`OFF_FAST_PEND, 32'h8000_0000);
    rreg(`OFF_NORM_PEND, 32'h8000_0000);
    wreg(`OFF_FORCE_LOW, 32'h0);
    rreg(`OFF_LEVEL_PEND, 32'h0);
    cq(9'h180);
  endtask
  task automatic t_mask;
    wreg(`OFF_FAST_EN, 32'h0);
    wreg(8'hdc, 32'h4);
    wreg(`OFF_NORM_EN, 32'h10);
    wreg(`OFF_FORCE_HIGH, 32'h80);
    cq(9'h124);
    wreg(`OFF_CONTROL, 32'h24);
    cq(9'h180);
    wreg(`OFF_CONTROL, 32'h23);
    cq(9'h124);
    wreg(`OFF_FAST_EN, 32'h10);
    cq(9'h0a4);
    wreg(`OFF_CONTROL, 32'h64);
    cq(9'h180);
    wreg(`OFF_CONTROL, 32'h63);
    cq(9'h0a4);
    wreg(`OFF_FAST_EN, 32'h0);
    cq(9'h180);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fast();
    t_prio();
    t_mask();
    report_and_stop();
  end
  // watchdog well beyond the hundred or so cycles the scenarios need
  initial begin
    #40000;
    errors++;
    report_and_stop();
  end
endmodule
